// file: src/vrp_defines.vh
`ifndef VRP_DEFINES_VH
`define VRP_DEFINES_VH

// Parameter addresses
`define VRP_ADDR_SYM 16'h0602
`define VRP_ADDR_VLIM 16'h0612
`define VRP_ADDR_ACC 16'h0614
`define VRP_ADDR_DEC 16'h0616
`define VRP_ADDR_JERK 16'h061A
`define VRP_ADDR_QS 16'h0624
`define VRP_ADDR_TGT 16'h0700
`define VRP_ADDR_PACKED 16'h0702

// Power-up values
`define VRP_RST_VLIM 16'h3390
`define VRP_RST_ACC 32'h00000258
`define VRP_RST_DEC 32'h000002EE
`define VRP_RST_JERK 16'h0000
`define VRP_RST_QS 32'h00001770
`define VRP_RST_TGT 32'h00000000

// Limits
`define VRP_ACC_MIN 32'h00000001
`define VRP_DEC_MIN 32'h000002EE
`define VRP_QS_MIN 32'h000000C8
`define VRP_RATE_MAX 32'h002DC6C0
`define VRP_VLIM_MIN 32'h0000003C
`define VRP_VLIM_MAX 32'h00003390
`define VRP_TGT_MIN 32'hFFFFCC70
`define VRP_TGT_MAX 32'h00003390
`define VRP_JERK_MAX 8'h80

// Ramp word scaling
`define VRP_SCALE 32'h0000000A
`define VRP_SAT16 16'hFFFF

// Packed word fields
`define VRP_PK_ACC_HI 31
`define VRP_PK_ACC_LO 16
`define VRP_PK_DEC_HI 15
`define VRP_PK_DEC_LO 0

// Error classes that select the quick-stop ramp
`define VRP_ERR_CLASS1 2'h1
`define VRP_ERR_CLASS2 2'h2

`endif

// file: src/vrp_ramp_latch.v
`include "vrp_defines.vh"

module vrp_ramp_latch #(
  parameter W = 128,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  mclk,
  rst_n,
  load,
  d,
  q
);
  input wire mclk;
  input wire rst_n;
  input wire load;
  input wire [W-1:0] d;
  output wire [W-1:0] q;

  reg [W-1:0] q_ff;
  wire [W-1:0] nxt_q;

  // Settings held here reach the profile only at a movement start; the target velocity bypasses this latch
  assign nxt_q = load ? d : q_ff;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule // vrp_ramp_latch

// file: src/vrp_rate_pack.v
`include "vrp_defines.vh"

module vrp_rate_pack (
  accel,
  decel,
  sym_word,
  packed_word
);
  input wire [31:0] accel;
  input wire [31:0] decel;
  output wire [15:0] sym_word;
  output wire [31:0] packed_word;

  wire [31:0] acc_div;
  wire [31:0] dec_div;
  wire [31:0] max_div;

  function [15:0] sat16;
    input [31:0] v;
    begin
      if (v[31:16] != 16'h0000) begin
        sat16 = `VRP_SAT16;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  // Constant divider; readback only, so its depth is off the write path
  assign acc_div = accel / `VRP_SCALE;
  assign dec_div = decel / `VRP_SCALE;
  assign max_div = (acc_div > dec_div) ? acc_div : dec_div;

  assign sym_word = sat16(max_div);
  assign packed_word = {sat16(acc_div), sat16(dec_div)};
endmodule // vrp_rate_pack

// file: src/vrp_ramp_params.v
`include "vrp_defines.vh"

module vrp_ramp_params (
  mclk,
  rst_n,
  par_req,
  par_we,
  par_addr,
  par_wdata,
  par_rdata,
  par_ack,
  par_err,
  standstill,
  mode_busy,
  motion_start,
  power_stage_en,
  sw_stop,
  err_class,
  ctrl_speed_limit,
  ref_vel_in,
  motion_finished,
  velocity_ref,
  ref_vel_limited,
  ramp_accel,
  ramp_decel,
  jerk_time_ms,
  jerk_filter_on,
  profile_vel_max
);
  input wire mclk;
  input wire rst_n;
  input wire par_req;
  input wire par_we;
  input wire [15:0] par_addr;
  input wire [31:0] par_wdata;
  output wire [31:0] par_rdata;
  output wire par_ack;
  output wire par_err;
  input wire standstill;
  input wire mode_busy;
  input wire motion_start;
  input wire power_stage_en;
  input wire sw_stop;
  input wire [1:0] err_class;
  input wire [15:0] ctrl_speed_limit;
  input wire [31:0] ref_vel_in;
  output wire motion_finished;
  output wire [31:0] velocity_ref;
  output wire [31:0] ref_vel_limited;
  output wire [31:0] ramp_accel;
  output wire [31:0] ramp_decel;
  output wire [15:0] jerk_time_ms;
  output wire jerk_filter_on;
  output wire [15:0] profile_vel_max;
  localparam LW = 128;
  // Stored parameter values as the master sees them
  reg [31:0] acc_ff;
  reg [31:0] dec_ff;
  reg [15:0] jerk_ff;
  reg [31:0] qs_ff;
  reg [15:0] vlim_ff;
  reg [31:0] tgt_ff;
  reg [31:0] nxt_acc;
  reg [31:0] nxt_dec;
  reg [15:0] nxt_jerk;
  reg [31:0] nxt_qs;
  reg [15:0] nxt_vlim;
  reg [31:0] nxt_tgt;
  // Access answer
  reg [31:0] rdata_ff;
  reg ack_ff;
  reg err_ff;
  reg [31:0] nxt_rdata;
  reg nxt_ack;
  reg nxt_err;
  // Profile-side outputs
  reg fin_ff;
  reg [31:0] vref_ff;
  reg [31:0] rlim_ff;
  reg [31:0] rdec_ff;
  wire nxt_fin;
  wire [31:0] nxt_vref;
  wire [31:0] nxt_rlim;
  wire [31:0] nxt_rdec;
  wire [LW-1:0] shadow_d;
  wire [LW-1:0] shadow_q;
  wire [31:0] act_acc;
  wire [31:0] act_dec;
  wire [15:0] act_jerk;
  wire [31:0] act_qs;
  wire [15:0] act_vlim;
  wire [15:0] sym_rd;
  wire [31:0] packed_rd;
  wire [31:0] pk_acc;
  wire [31:0] pk_dec;
  wire [31:0] sym_rate;
  wire [15:0] speed_lim;
  wire quick_stop;
  function in_range;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction
  function rates_ok;
    input [31:0] a;
    input [31:0] d;
    begin
      rates_ok = in_range(a, `VRP_ACC_MIN, `VRP_RATE_MAX) && in_range(d, `VRP_DEC_MIN, `VRP_RATE_MAX);
    end
  endfunction
  // Ramp word unit is 10 RPM/s: v*8 + v*2
  function [31:0] scale10;
    input [15:0] v;
    begin
      scale10 = {13'h0000, v, 3'h0} + {15'h0000, v, 1'b0};
    end
  endfunction
  function jerk_code_ok;
    input [31:0] v;
    reg [7:0] lo;
    begin
      lo = v[7:0];
      jerk_code_ok = (v[31:8] == 24'h000000) && ((lo & (lo - 8'h01)) == 8'h00) && (lo <= `VRP_JERK_MAX);
    end
  endfunction
  // Symmetric clamp of a signed velocity to +/- lim
  function [31:0] clamp_vel;
    input [31:0] v;
    input [15:0] lim;
    reg [31:0] pos;
    reg [31:0] neg;
    begin
      pos = {16'h0000, lim};
      neg = ~pos + 32'h00000001;
      if ($signed(v) > $signed(pos)) begin
        clamp_vel = pos;
      end else if ($signed(v) < $signed(neg)) begin
        clamp_vel = neg;
      end else begin
        clamp_vel = v;
      end
    end
  endfunction
  assign pk_acc = scale10(par_wdata[`VRP_PK_ACC_HI:`VRP_PK_ACC_LO]);
  assign pk_dec = scale10(par_wdata[`VRP_PK_DEC_HI:`VRP_PK_DEC_LO]);
  assign sym_rate = scale10(par_wdata[15:0]);

  vrp_rate_pack u_pack (
    .accel(acc_ff),
    .decel(dec_ff),
    .sym_word(sym_rd),
    .packed_word(packed_rd)
  );

  // Parameter access: one request per cycle, answered on the next edge
  always @* begin
    nxt_acc = acc_ff;
    nxt_dec = dec_ff;
    nxt_jerk = jerk_ff;
    nxt_qs = qs_ff;
    nxt_vlim = vlim_ff;
    nxt_tgt = tgt_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = par_req;
    nxt_err = 1'b0;
    if (par_req) begin
      case (par_addr)
        `VRP_ADDR_SYM: begin
          if (par_we) begin
            if ((par_wdata[31:16] == 16'h0000) && rates_ok(sym_rate, sym_rate)) begin
              nxt_acc = sym_rate;
              nxt_dec = sym_rate;
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = {16'h0000, sym_rd};
          end
        end
        `VRP_ADDR_PACKED: begin
          if (par_we) begin
            if (rates_ok(pk_acc, pk_dec)) begin
              nxt_acc = pk_acc;
              nxt_dec = pk_dec;
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = packed_rd;
          end
        end
        `VRP_ADDR_ACC: begin
          if (par_we) begin
            if (in_range(par_wdata, `VRP_ACC_MIN, `VRP_RATE_MAX)) begin
              nxt_acc = par_wdata;
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = acc_ff;
          end
        end
        `VRP_ADDR_DEC: begin
          if (par_we) begin
            if (in_range(par_wdata, `VRP_DEC_MIN, `VRP_RATE_MAX)) begin
              nxt_dec = par_wdata;
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = dec_ff;
          end
        end
        `VRP_ADDR_JERK: begin
          if (par_we) begin
            if (jerk_code_ok(par_wdata) && fin_ff) begin
              nxt_jerk = par_wdata[15:0];
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = {16'h0000, jerk_ff};
          end
        end
        `VRP_ADDR_QS: begin
          if (par_we) begin
            if (in_range(par_wdata, `VRP_QS_MIN, `VRP_RATE_MAX)) begin
              nxt_qs = par_wdata;
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = qs_ff;
          end
        end
        `VRP_ADDR_VLIM: begin
          if (par_we) begin
            if (in_range(par_wdata, `VRP_VLIM_MIN, `VRP_VLIM_MAX) && !power_stage_en) begin
              nxt_vlim = par_wdata[15:0];
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = {16'h0000, vlim_ff};
          end
        end
        `VRP_ADDR_TGT: begin
          if (par_we) begin
            if (($signed(par_wdata) >= $signed(`VRP_TGT_MIN)) && ($signed(par_wdata) <= $signed(`VRP_TGT_MAX))) begin
              nxt_tgt = par_wdata;
            end else begin
              nxt_err = 1'b1;
            end
          end else begin
            nxt_rdata = tgt_ff;
          end
        end
        default: begin
          nxt_err = 1'b1;
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= `VRP_RST_ACC;
      dec_ff <= `VRP_RST_DEC;
      jerk_ff <= `VRP_RST_JERK;
      qs_ff <= `VRP_RST_QS;
      vlim_ff <= `VRP_RST_VLIM;
      tgt_ff <= `VRP_RST_TGT;
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      dec_ff <= nxt_dec;
      jerk_ff <= nxt_jerk;
      qs_ff <= nxt_qs;
      vlim_ff <= nxt_vlim;
      tgt_ff <= nxt_tgt;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
    end
  end

  // A write in the same cycle as a start waits for the following start
  assign shadow_d = {acc_ff, dec_ff, jerk_ff, qs_ff, vlim_ff};

  vrp_ramp_latch #(
    .W(LW),
    .RST({`VRP_RST_ACC, `VRP_RST_DEC, `VRP_RST_JERK, `VRP_RST_QS, `VRP_RST_VLIM})
  ) u_shadow (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(motion_start),
    .d(shadow_d),
    .q(shadow_q)
  );

  assign act_acc = shadow_q[127:96];
  assign act_dec = shadow_q[95:64];
  assign act_jerk = shadow_q[63:48];
  assign act_qs = shadow_q[47:16];
  assign act_vlim = shadow_q[15:0];
  assign nxt_fin = standstill && !mode_busy;
  // Controller limit can only tighten the profile limit
  assign speed_lim = (ctrl_speed_limit < act_vlim) ? ctrl_speed_limit : act_vlim;
  assign nxt_vref = clamp_vel(tgt_ff, speed_lim);
  assign nxt_rlim = clamp_vel(ref_vel_in, act_vlim);

  assign quick_stop = sw_stop || (err_class == `VRP_ERR_CLASS1) || (err_class == `VRP_ERR_CLASS2);
  assign nxt_rdec = quick_stop ? act_qs : act_dec;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fin_ff <= 1'b0;
      vref_ff <= 32'h00000000;
      rlim_ff <= 32'h00000000;
      rdec_ff <= `VRP_RST_DEC;
    end else begin
      fin_ff <= nxt_fin;
      vref_ff <= nxt_vref;
      rlim_ff <= nxt_rlim;
      rdec_ff <= nxt_rdec;
    end
  end

  assign par_rdata = rdata_ff;
  assign par_ack = ack_ff;
  assign par_err = err_ff;
  assign motion_finished = fin_ff;
  assign velocity_ref = vref_ff;
  assign ref_vel_limited = rlim_ff;
  assign ramp_accel = act_acc;
  assign ramp_decel = rdec_ff;
  assign jerk_time_ms = act_jerk;
  assign jerk_filter_on = (act_jerk != 16'h0000);
  assign profile_vel_max = act_vlim;
endmodule // vrp_ramp_params

// file: dv/vrp_ramp_chk.sv
`include "vrp_defines.vh"

module vrp_ramp_chk (
  input wire mclk,
  input wire rst_n,
  input wire par_req,
  input wire par_we,
  input wire [15:0] par_addr,
  input wire par_ack,
  input wire par_err,
  input wire standstill,
  input wire mode_busy,
  input wire motion_start,
  input wire power_stage_en,
  input wire [31:0] ref_vel_in,
  input wire motion_finished,
  input wire [31:0] ref_vel_limited,
  input wire [31:0] ramp_accel,
  input wire [15:0] jerk_time_ms,
  input wire jerk_filter_on,
  input wire [15:0] profile_vel_max
);
  timeunit 1ns;
  timeprecision 1ns;

  function automatic logic [31:0] clampv(input logic [31:0] v, input logic [31:0] lim);
    if ($signed(v) > $signed(lim)) clampv = lim;
    else if ($signed(v) < -$signed(lim)) clampv = -lim;
    else clampv = v;
  endfunction

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ack_timing_a: assert property (par_ack == $past(par_req))
    else $error("answer missing after request");
  err_with_ack_a: assert property (par_err |-> par_ack && $past(par_req))
    else $error("refusal without answer");
  finish_track_a: assert property (1 |=> motion_finished == $past(standstill && !mode_busy))
    else $error("finished flag wrong");
  jerk_lock_a: assert property (par_req && par_we && par_addr == `VRP_ADDR_JERK && !motion_finished |=> par_err)
    else $error("jerk write taken during motion");
  limit_lock_a: assert property (par_req && par_we && par_addr == `VRP_ADDR_VLIM && power_stage_en |=> par_err)
    else $error("limit write taken with power on");
  shadow_hold_a: assert property (!$past(motion_start) |-> $stable(ramp_accel) && $stable(profile_vel_max) && $stable(jerk_time_ms))
    else $error("active ramp changed without start");
  jerk_code_a: assert property ($onehot0(jerk_time_ms) && jerk_time_ms <= 16'h80 && jerk_filter_on == |jerk_time_ms)
    else $error("bad active jerk code");
  ref_clamp_a: assert property (1 |=> ref_vel_limited == clampv($past(ref_vel_in), {16'h0, $past(profile_vel_max)}))
    else $error("reference not clamped");

  cover property (motion_start);
  cover property (par_req && par_we && par_addr == `VRP_ADDR_JERK && motion_finished);
  cover property (par_ack && par_err);
endmodule // vrp_ramp_chk

bind vrp_ramp_params vrp_ramp_chk i_vrp_ramp_chk (.mclk, .rst_n, .par_req, .par_we, .par_addr, .par_ack, .par_err,
  .standstill, .mode_busy, .motion_start, .power_stage_en, .ref_vel_in, .motion_finished, .ref_vel_limited,
  .ramp_accel, .jerk_time_ms, .jerk_filter_on, .profile_vel_max);

// file: dv/vrp_master.sv
module vrp_master (
  input wire mclk,
  output logic par_req,
  output logic par_we,
  output logic [15:0] par_addr,
  output logic [31:0] par_wdata,
  input wire [31:0] par_rdata,
  input wire par_ack,
  input wire par_err
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    par_req = 1'b0;
    par_we = 1'b0;
    par_addr = 16'h0;
    par_wdata = 32'h0;
  end

  task automatic access(input logic we, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic ok);
    int n;
    @(negedge mclk);
    par_req = 1'b1;
    par_we = we;
    par_addr = a;
    par_wdata = d;
    @(negedge mclk);
    par_req = 1'b0;
    // Released lines flip so a stale value never looks valid
    par_addr = ~a;
    par_wdata = ~d;
    n = 0;
    while (par_ack !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    ok = (par_ack === 1'b1);
    q = par_rdata;
    e = par_err;
  endtask
endmodule // vrp_master

// file: dv/tb_top.sv
`include "vrp_defines.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, standstill, mode_busy, motion_start, power_stage_en, sw_stop;
  logic par_req, par_we, par_ack, par_err, motion_finished, jerk_filter_on;
  logic [1:0] err_class;
  logic [15:0] par_addr, ctrl_speed_limit, jerk_time_ms, profile_vel_max;
  logic [31:0] par_wdata, par_rdata, ref_vel_in, velocity_ref, ref_vel_limited, ramp_accel, ramp_decel;
  int n_mismatch = 0;
  int checked = 0;

  vrp_ramp_params i_vrp_ramp_params (.mclk, .rst_n, .par_req, .par_we, .par_addr, .par_wdata, .par_rdata,
    .par_ack, .par_err, .standstill, .mode_busy, .motion_start, .power_stage_en, .sw_stop, .err_class,
    .ctrl_speed_limit, .ref_vel_in, .motion_finished, .velocity_ref, .ref_vel_limited, .ramp_accel,
    .ramp_decel, .jerk_time_ms, .jerk_filter_on, .profile_vel_max);
  vrp_master bus_master (.mclk, .par_req, .par_we, .par_addr, .par_wdata, .par_rdata, .par_ack, .par_err);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic close_out;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] d, input logic ee,
                      input logic [31:0] eq);
    logic [31:0] q;
    logic e, ok;
    bus_master.access(we, a, d, q, e, ok);
    if (!ok) begin
      n_mismatch++;
      close_out();
    end else begin
      chk({31'h0, e}, {31'h0, ee});
      if (!we) chk(q, eq);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee);
    xfer(1'b1, a, d, ee, 32'h0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] eq);
    xfer(1'b0, a, 32'h0, 1'b0, eq);
  endtask

  task automatic w2;
    repeat (2) @(negedge mclk);
  endtask

  task automatic start_move;
    @(negedge mclk);
    motion_start = 1'b1;
    @(negedge mclk);
    motion_start = 1'b0;
    w2();
  endtask

  task automatic sc_defaults;
    rd(`VRP_ADDR_ACC, 32'h258);
    rd(`VRP_ADDR_DEC, 32'h2EE);
    rd(`VRP_ADDR_QS, 32'h1770);
    rd(`VRP_ADDR_VLIM, 32'h3390);
    rd(`VRP_ADDR_JERK, 32'h0);
    rd(`VRP_ADDR_SYM, 32'h4B);
    rd(`VRP_ADDR_PACKED, 32'h3C004B);
    xfer(1'b0, 16'h0, 32'h0, 1'b1, 32'h0);
    chk(ramp_decel, 32'h2EE);
  endtask

  task automatic sc_words;
    wr(`VRP_ADDR_PACKED, 32'h640050, 1'b0);
    rd(`VRP_ADDR_ACC, 32'h3E8);
    rd(`VRP_ADDR_DEC, 32'h320);
    chk(ramp_accel, 32'h258);
    start_move();
    chk(ramp_accel, 32'h3E8);
    chk(ramp_decel, 32'h320);
    wr(`VRP_ADDR_PACKED, 32'h50, 1'b1);
    wr(`VRP_ADDR_PACKED, 32'hC8004A, 1'b1);
    rd(`VRP_ADDR_ACC, 32'h3E8);
    rd(`VRP_ADDR_DEC, 32'h320);
    wr(`VRP_ADDR_SYM, 32'h1B58, 1'b0);
    rd(`VRP_ADDR_DEC, 32'h11170);
    rd(`VRP_ADDR_SYM, 32'h1B58);
    wr(`VRP_ADDR_SYM, 32'h4A, 1'b1);
    wr(`VRP_ADDR_SYM, 32'h10000, 1'b1);
    wr(`VRP_ADDR_ACC, 32'h2DC6C0, 1'b0);
    rd(`VRP_ADDR_SYM, 32'hFFFF);
    rd(`VRP_ADDR_PACKED, 32'hFFFF1B58);
    wr(`VRP_ADDR_ACC, 32'h2DC6C1, 1'b1);
    wr(`VRP_ADDR_DEC, 32'h2ED, 1'b1);
  endtask

  task automatic sc_jerk;
    int i;
    standstill = 1'b0;
    w2();
    chk({31'h0, motion_finished}, 32'h0);
    wr(`VRP_ADDR_JERK, 32'h4, 1'b1);
    standstill = 1'b1;
    mode_busy = 1'b1;
    w2();
    chk({31'h0, motion_finished}, 32'h0);
    wr(`VRP_ADDR_JERK, 32'h4, 1'b1);
    mode_busy = 1'b0;
    w2();
    chk({31'h0, motion_finished}, 32'h1);
    wr(`VRP_ADDR_JERK, 32'h0, 1'b0);
    for (i = 0; i < 8; i++) begin
      wr(`VRP_ADDR_JERK, 32'h1 << i, 1'b0);
    end
    wr(`VRP_ADDR_JERK, 32'h3, 1'b1);
    wr(`VRP_ADDR_JERK, 32'h100, 1'b1);
    chk({16'h0, jerk_time_ms}, 32'h0);
    start_move();
    chk({16'h0, jerk_time_ms}, 32'h80);
    chk({31'h0, jerk_filter_on}, 32'h1);
  endtask

  task automatic sc_limits;
    power_stage_en = 1'b1;
    wr(`VRP_ADDR_VLIM, 32'h3E8, 1'b1);
    power_stage_en = 1'b0;
    wr(`VRP_ADDR_VLIM, 32'h3B, 1'b1);
    wr(`VRP_ADDR_VLIM, 32'h3E8, 1'b0);
    chk({16'h0, profile_vel_max}, 32'h3390);
    start_move();
    ref_vel_in = 32'h1388;
    w2();
    chk(ref_vel_limited, 32'h3E8);
    wr(`VRP_ADDR_TGT, 32'hFFFFEC78, 1'b0);
    w2();
    chk(velocity_ref, 32'hFFFFFC18);
    ctrl_speed_limit = 16'h320;
    w2();
    chk(velocity_ref, 32'hFFFFFCE0);
    wr(`VRP_ADDR_TGT, 32'h3391, 1'b1);
    wr(`VRP_ADDR_QS, 32'hC7, 1'b1);
    wr(`VRP_ADDR_QS, 32'hC8, 1'b0);
    err_class = 2'h2;
    w2();
    chk(ramp_decel, 32'h1770);
    err_class = 2'h1;
    w2();
    chk(ramp_decel, 32'h1770);
    err_class = 2'h3;
    w2();
    chk(ramp_decel, 32'h11170);
    err_class = 2'h0;
    sw_stop = 1'b1;
    w2();
    chk(ramp_decel, 32'h1770);
    sw_stop = 1'b0;
    w2();
    chk(ramp_decel, 32'h11170);
    sw_stop = 1'b1;
    start_move();
    chk(ramp_decel, 32'hC8);
    sw_stop = 1'b0;
    w2();
    chk(ramp_decel, 32'h11170);
  endtask

  initial begin
    rst_n = 1'b0;
    standstill = 1'b1;
    mode_busy = 1'b0;
    motion_start = 1'b0;
    power_stage_en = 1'b0;
    sw_stop = 1'b0;
    err_class = 2'h0;
    ctrl_speed_limit = 16'h3390;
    ref_vel_in = 32'h0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    w2();
    sc_defaults();
    sc_words();
    sc_jerk();
    sc_limits();
    close_out();
  end
endmodule // tb_top
